// file: common/i2c_slave_pkg.sv
// Types shared by the slave status block
package i2c_slave_pkg;
  // Gray code along idle, address, address ack, receive, receive ack, transmit, transmit ack
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RXD  = 3'h2,
    ST_RACK = 3'h6,
    ST_TXD  = 3'h7,
    ST_TACK = 3'h5
  } link_state_e;

  typedef struct packed {
    logic smb_mode;
    logic str_en;
    logic gc_en;
    logic ack_bit;
    logic str_sel;
    logic en;
  } ctrl_s;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic q;
  } sync_s;
endpackage : i2c_slave_pkg

// file: common/i2c_slave_regs.svh
// Register offsets, field positions, reset values and timing figures of the slave block
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

`define OFS_CONTROL        8'h00
`define OFS_STATUS         8'h04
`define OFS_ENABLE         8'h08
`define OFS_STATUS2        8'h0C
`define OFS_ENABLE2        8'h10
`define OFS_SLAVE_ADDR     8'h14
`define OFS_DATA_BUF       8'h18
`define OFS_MEM_PTR        8'h1C

`define CTRL_EN_BIT        0
`define CTRL_DIR_BIT       2
`define CTRL_STR_SEL_BIT   4
`define CTRL_ACK_BIT       5
`define CTRL_GC_EN_BIT     8
`define CTRL_STR_EN_BIT    9
`define CTRL_SMB_BIT       10
`define CTRL_RESET         16'h0001
`define CTRL_WR_MASK       16'h0731

`define ST_START_BIT       0
`define ST_TXDONE_BIT      1
`define ST_RXRDY_BIT       2
`define ST_STRETCH_BIT     3
`define ST_TIMEOUT_BIT     4
`define ST_AMATCH_BIT      5
`define ST_NACK_BIT        7
`define ST_GCALL_BIT       8
`define ST_OVERRUN_BIT     9
`define ST_SCL_BIT         10
`define ST_BUSY_BIT        14
`define ST_BUSACT_BIT      15
`define ST_SET_MASK        16'h0333
`define ST_CLR_MASK        16'h01BF
`define IE_MASK            16'h03BF

`define ST2_TXCOPY_BIT     1
`define ST2_MADDR_BIT      3
`define ST2_APHASE_BIT     4
`define ST2_STOP_BIT       5
`define ST2_SET_MASK       16'h0038
`define ST2_CLR_MASK       16'h003A
`define IE2_MASK           16'h0038

`define SLA_RESET          8'h36
`define GCALL_ADDR         8'h00
`define MPTR_MASK          16'h07FF
`define FLAGS_RESET        16'h0000

`define BITS_PER_BYTE      4'h8
`define APHASE_EDGES       4'h2
`define TIMEOUT_MS         30
`define CLK_KHZ            125000
`endif

// file: dv/i2c_host_model.sv
// Behavioural I2C host driving open-drain SCL and SDA
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Wait bounded so a stuck stretch cannot hang the run
  // Phases outlast the slave's filter delay so its SDA moves only while SCL is low
  task automatic rise;
    int t = 0;
    scl_low = 1'b0;
    while (!scl_in && t < 4000) begin
      #16;
      t++;
    end
    #64;
  endtask : rise
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #64;
    rise();
    s = sda_in;
    scl_low = 1'b1;
    #64;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] r,
                         output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      r[i] = s;
    end
    bit_io(last, s);
    ok = !s;
  endtask : byte_io
  task automatic start_c;
    sda_low = 1'b0;
    #64;
    rise();
    sda_low = 1'b1;
    #64;
    scl_low = 1'b1;
    #64;
  endtask : start_c
  task automatic stop_c;
    sda_low = 1'b1;
    #64;
    rise();
    sda_low = 1'b0;
    #64;
  endtask : stop_c
endmodule : i2c_host_model

// file: dv/i2c_slave_status_sva.sv
// Port-level checker for the slave status block
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module i2c_slave_status_sva (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq
);
  logic       rd;
  logic       wr;
  logic       off_r;
  logic       en_r;
  logic       en2_r;
  logic       sclp_r;
  logic [3:0] sclc_r;
  assign rd = wb_ack_o && wb_cyc_i && !wb_we_i;
  assign wr = wb_ack_o && wb_cyc_i && wb_we_i && (wb_sel_i[1:0] == 2'h3);
  // Shadows of software writes; partial-lane writes are not tracked
  always_ff @(posedge clock) begin
    sclp_r <= scl_i;
    if (srst) begin
      off_r  <= 1'b0;
      en_r   <= 1'b0;
      en2_r  <= 1'b0;
      sclc_r <= 4'h0;
    end else begin
      sclc_r <= (scl_i != sclp_r) ? 4'h0 : (sclc_r == 4'hF) ? sclc_r : sclc_r + 4'h1;
      if (wr && wb_adr_i == `OFS_CONTROL) off_r <= !wb_dat_i[0];
      if (wr && wb_adr_i == `OFS_ENABLE) en_r <= |(wb_dat_i[15:0] & `IE_MASK);
      if (wr && wb_adr_i == `OFS_ENABLE2) en2_r <= |(wb_dat_i[15:0] & `IE2_MASK);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  scl_level_a: assert property (
    rd && wb_adr_i == `OFS_STATUS && sclc_r > 4'h9 |-> wb_dat_o[10] == scl_i)
    else $error("status SCL level differs from pin");
  sla_upper_a: assert property (
    rd && wb_adr_i == `OFS_SLAVE_ADDR |-> wb_dat_o[31:8] == 24'h000000)
    else $error("slave address upper bits not zero");
  enable_bits_a: assert property (
    rd && wb_adr_i == `OFS_ENABLE |-> (wb_dat_o & ~{16'h0000, `IE_MASK}) == 32'h0)
    else $error("enable register reserved bits set");
  enable2_bits_a: assert property (
    rd && wb_adr_i == `OFS_ENABLE2 |-> (wb_dat_o & ~{16'h0000, `IE2_MASK}) == 32'h0)
    else $error("second enable reserved bits set");
  status2_bits_a: assert property (
    rd && wb_adr_i == `OFS_STATUS2 |-> (wb_dat_o & ~{16'h0000, `ST2_CLR_MASK}) == 32'h0)
    else $error("second status reserved bits set");
  irq_masked_a: assert property ((!en_r && !en2_r) [*2] |-> !irq)
    else $error("interrupt with every enable cleared");
  off_bus_a: assert property (off_r && rd && wb_adr_i == `OFS_STATUS |-> !wb_dat_o[15])
    else $error("bus activity shown while disabled");
  off_pins_a: assert property (off_r [*2] |-> !scl_oe && !sda_oe)
    else $error("pins held while disabled");
endmodule : i2c_slave_status_sva

// file: dv/i2c_slave_status_tb.sv
// Self-checking bench for the slave status block
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module i2c_slave_status_tb;
  localparam int TO_CYC = 200;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, scl_oe, sda_oe, irq, scl_low, sda_low, scl_w, sda_w, ok;
  logic [7:0]  r;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);
  always #4 clock = ~clock;
  i2c_slave_status #(.TIMEOUT_CYCLES(TO_CYC)) dut_u (
    .clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
    .irq(irq));
  i2c_host_model host_u (.scl_in(scl_w), .sda_in(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  task automatic conclude;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [15:0] q);
    int n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) n_fail++;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    `CHK(q & m, e)
  endtask : rd
  task automatic irq_is(input logic e);
    @(posedge clock);
    #1;
    `CHK(irq, e)
  endtask : irq_is
  task automatic t_reset;
    rd(`OFS_CONTROL, 16'hFFFF, 16'h0001);
    rd(`OFS_STATUS, 16'hFFFF, 16'h0400);
    rd(`OFS_ENABLE, 16'hFFFF, 16'h0000);
    rd(`OFS_STATUS2, 16'hFFFF, 16'h0000);
    rd(`OFS_ENABLE2, 16'hFFFF, 16'h0000);
    rd(`OFS_SLAVE_ADDR, 16'hFFFF, 16'h0036);
    rd(8'h20, 16'hFFFF, 16'h0000);
  endtask : t_reset
  task automatic t_soft;
    int p1[6] = '{9, 8, 5, 4, 1, 0};
    int p2[3] = '{5, 4, 3};
    wr(`OFS_STATUS, 16'hFFFF);
    rd(`OFS_STATUS, 16'hFFFF, 16'h0733);
    foreach (p1[k]) begin
      wr(`OFS_ENABLE, 16'h0001 << p1[k]);
      irq_is(1'b1);
    end
    wr(`OFS_ENABLE, 16'h0004);
    irq_is(1'b0);
    wr(`OFS_STATUS, 16'h0000);
    rd(`OFS_STATUS, 16'hFFFF, 16'h0600);
    wr(`OFS_ENABLE, 16'h0200);
    irq_is(1'b1);
    rd(`OFS_DATA_BUF, 16'h0000, 16'h0000);
    rd(`OFS_STATUS, 16'hFFFF, 16'h0400);
    irq_is(1'b0);
    wr(`OFS_ENABLE, 16'h0000);
    wr(`OFS_STATUS2, 16'hFFFF);
    rd(`OFS_STATUS2, 16'hFFFF, 16'h0038);
    foreach (p2[k]) begin
      wr(`OFS_ENABLE2, 16'h0001 << p2[k]);
      irq_is(1'b1);
    end
    wr(`OFS_STATUS2, 16'h0000);
    irq_is(1'b0);
    wr(`OFS_ENABLE2, 16'h0000);
  endtask : t_soft
  task automatic t_write;
    host_u.start_c();
    host_u.byte_io(8'h36, 1'b1, r, ok);
    `CHK(ok, 1'b1)
    rd(`OFS_STATUS, 16'hC000, 16'hC000);
    host_u.byte_io(8'hA5, 1'b1, r, ok);
    host_u.byte_io(8'h5C, 1'b1, r, ok);
    host_u.stop_c();
    rd(`OFS_STATUS, 16'hFFFF, 16'h0625);
    rd(`OFS_STATUS2, 16'hFFFF, 16'h0038);
    rd(`OFS_MEM_PTR, 16'hFFFF, 16'h00A5);
    rd(`OFS_DATA_BUF, 16'h00FF, 16'h005C);
    wr(`OFS_STATUS, 16'h0000);
    wr(`OFS_STATUS2, 16'h0000);
    rd(`OFS_STATUS, 16'hFFFF, 16'h0400);
  endtask : t_write
  task automatic t_miss;
    host_u.start_c();
    host_u.byte_io(8'h50, 1'b1, r, ok);
    `CHK(ok, 1'b0)
    rd(`OFS_STATUS, 16'h8021, 16'h8001);
    wr(`OFS_CONTROL, 16'h0000);
    rd(`OFS_STATUS, 16'h8000, 16'h0000);
    host_u.stop_c();
    wr(`OFS_CONTROL, 16'h0001);
  endtask : t_miss
  task automatic t_gcall;
    for (int g = 0; g < 2; g++) begin
      wr(`OFS_CONTROL, g ? 16'h0101 : 16'h0001);
      wr(`OFS_STATUS, 16'h0000);
      host_u.start_c();
      host_u.byte_io(8'h00, 1'b1, r, ok);
      `CHK(ok, g[0])
      host_u.stop_c();
      rd(`OFS_STATUS, 16'h0100, g ? 16'h0100 : 16'h0000);
    end
    wr(`OFS_CONTROL, 16'h0001);
  endtask : t_gcall
  task automatic t_read;
    wr(`OFS_STATUS, 16'h0000);
    wr(`OFS_DATA_BUF, 16'h003C);
    host_u.start_c();
    host_u.byte_io(8'h37, 1'b1, r, ok);
    host_u.byte_io(8'hFF, 1'b0, r, ok);
    `CHK(r, 8'h3C)
    rd(`OFS_STATUS, 16'h00A2, 16'h0022);
    host_u.byte_io(8'hFF, 1'b1, r, ok);
    host_u.stop_c();
    rd(`OFS_STATUS, 16'h0082, 16'h0082);
    rd(`OFS_STATUS2, 16'h0002, 16'h0002);
    rd(`OFS_SLAVE_ADDR, 16'hFFFF, 16'h0037);
  endtask : t_read
  task automatic t_stretch;
    int n = 0;
    wr(`OFS_CONTROL, 16'h0201);
    host_u.start_c();
    host_u.byte_io(8'h36, 1'b1, r, ok);
    while (scl_oe !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    `CHK(scl_oe, 1'b1)
    rd(`OFS_STATUS, 16'h0008, 16'h0008);
    wr(`OFS_STATUS, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    `CHK(scl_oe, 1'b0)
    wr(`OFS_CONTROL, 16'h0001);
    host_u.stop_c();
  endtask : t_stretch
  task automatic t_timeout;
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_CONTROL, m ? 16'h0401 : 16'h0001);
      wr(`OFS_STATUS, 16'h0000);
      host_u.start_c();
      host_u.byte_io(8'h36, 1'b1, r, ok);
      repeat (TO_CYC + 20) @(posedge clock);
      rd(`OFS_STATUS, 16'h0010, m ? 16'h0010 : 16'h0000);
      host_u.stop_c();
    end
    wr(`OFS_CONTROL, 16'h0001);
  endtask : t_timeout
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (6) @(posedge clock);
    t_reset();
    t_soft();
    t_write();
    t_miss();
    t_gcall();
    t_read();
    t_stretch();
    t_timeout();
    conclude();
  end
endmodule : i2c_slave_status_tb
bind i2c_slave_status i2c_slave_status_sva chk_u (.*);

// file: rtl/i2c_slave_status.sv
// I2C slave link engine with status flags, enables, interrupt and Wishbone registers
// Functional notes
// RULE1: Bus activity set on START or repeated START, cleared on STOP, zero when disabled.
// RULE2: Transaction-active bit reflects engine taking part in a transfer; read-only.
// RULE3: Read-only status bit shows present SCL level.
// RULE4: Overrun set on second byte before buffer read; only a buffer read clears it.
// RULE5: General-call flag set on address 00h when enabled; stays until cleared.
// RULE6: After each transmitted byte, NACK flag takes host acknowledge value.
// RULE7: Address-match flag set when received address equals programmed address.
// RULE8: Timeout flag set when SCL low over 30 ms with timeout enabled; code counts SCL low only while the engine is not idle.
// RULE9: Stretch flag set while holding SCL low; SCL released once flag cleared.
// RULE10: Receive-ready flag set by hardware when a data byte lands in buffer.
// RULE11: Transmit-complete flag set after byte out and acknowledge sampled; copy too.
// RULE12: Start flag set on START and repeated START; stays until cleared.
// RULE13: Writing one sets overrun, general-call, match, tx-done, start, stop, memory flags.
// RULE14: First enable register gates same-position flags 9..0 to the interrupt.
// RULE15: Stop flag in second status register set on STOP detection.
// RULE16: Address-phase flag set after START plus two SCL clocks.
// RULE17: Detected memory address copied into pointer bits 7:0, memory flag set.
// RULE18: First data byte after write-direction match is the memory address.
// RULE19: Second enable register gates stop, address-phase, memory flags at 5, 4, 3.
// RULE20: Slave address holds address in 7:1, direction in 0, resets 36h.
// RULE21: Software clears latched flags except overrun by writing zero; hardware clears only overrun, NACK and, on disable, stretch.
// RULE22: Timeout counting runs only while the timeout-mode bit is one.
// RULE23: General call answered only while general-call enable is one.
// RULE24: Interrupt is OR of all enabled flags, held until all are cleared.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module i2c_slave_status #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_MS * `CLK_KHZ,
  parameter int TO_W           = 22
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  localparam logic [TO_W-1:0] TO_LIM   = TO_W'(TIMEOUT_CYCLES - 1);
  localparam logic [15:0]     CTRL_RST = `CTRL_RESET;

  typedef struct packed {
    i2c_slave_pkg::ctrl_s       ctrl;
    logic [15:0]                st;
    logic [15:0]                ie;
    logic [15:0]                st2;
    logic [15:0]                ie2;
    logic [7:0]                 sla;
    logic [7:0]                 tx_buf;
    logic [7:0]                 rx_buf;
    logic                       rx_unread;
    logic [10:0]                mptr;
    i2c_slave_pkg::link_state_e state;
    logic [3:0]                 cnt;
    logic [7:0]                 shift;
    logic                       rd_dir;
    logic                       expect_mem;
    logic                       host_ack;
    logic                       bus_act;
    logic                       scl_d;
    logic                       sda_d;
    logic [TO_W-1:0]            tocnt;
    logic                       ack;
    logic [31:0]                dat;
    logic                       irq;
    logic                       sda_oe;
    logic                       scl_oe;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic   scl_f;
  logic   sda_f;

  pin_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
    .clock (clock),
    .srst  (srst),
    .din   (scl_i),
    .q     (scl_f)
  );

  pin_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
    .clock (clock),
    .srst  (srst),
    .din   (sda_i),
    .q     (sda_f)
  );

  function automatic logic [15:0] ctrl_word(input state_s s);
    logic [15:0] w;
    w                    = 16'h0000;
    w[`CTRL_EN_BIT]      = s.ctrl.en;
    w[`CTRL_DIR_BIT]     = s.rd_dir;
    w[`CTRL_STR_SEL_BIT] = s.ctrl.str_sel;
    w[`CTRL_ACK_BIT]     = s.ctrl.ack_bit;
    w[`CTRL_GC_EN_BIT]   = s.ctrl.gc_en;
    w[`CTRL_STR_EN_BIT]  = s.ctrl.str_en;
    w[`CTRL_SMB_BIT]     = s.ctrl.smb_mode;
    return w;
  endfunction : ctrl_word

  always_comb begin
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        req;
    logic        wr;
    logic        rd;
    logic        busy;
    logic        at_last;
    logic        hit;
    logic        gcall;
    logic        set_str;
    logic [15:0] wmask;
    logic [15:0] wd;
    logic [15:0] st_live;
    logic [15:0] cw;
    s_nxt    = s_r;
    scl_rise = scl_f & ~s_r.scl_d;
    scl_fall = ~scl_f & s_r.scl_d;
    start_ev = s_r.sda_d & ~sda_f & scl_f & s_r.scl_d;
    stop_ev  = ~s_r.sda_d & sda_f & scl_f & s_r.scl_d;
    req      = wb_cyc_i & wb_stb_i;
    // Write and read side effects land on the edge the master takes ack
    wr       = req & s_r.ack & wb_we_i;
    rd       = req & s_r.ack & ~wb_we_i;
    busy     = (s_r.state != i2c_slave_pkg::ST_IDLE);
    at_last  = (s_r.cnt == `BITS_PER_BYTE);
    hit      = 1'b0;
    gcall    = 1'b0;
    set_str  = 1'b0;
    wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wd       = wb_dat_i[15:0];
    s_nxt.scl_d = scl_f;
    s_nxt.sda_d = sda_f;

    st_live = s_r.st;
    st_live[`ST_BUSACT_BIT] = s_r.bus_act; // RULE1
    st_live[`ST_BUSY_BIT]   = busy; // RULE2
    st_live[`ST_SCL_BIT]    = scl_f; // RULE3
    cw = ctrl_word(s_r);

    // Register bus: single-wait answer, unmapped offsets read zero
    s_nxt.ack = req & ~s_r.ack;
    if (req & ~s_r.ack) begin
      case (wb_adr_i)
        `OFS_CONTROL:    s_nxt.dat = {16'h0000, cw};
        `OFS_STATUS:     s_nxt.dat = {16'h0000, st_live};
        `OFS_ENABLE:     s_nxt.dat = {16'h0000, s_r.ie};
        `OFS_STATUS2:    s_nxt.dat = {16'h0000, s_r.st2};
        `OFS_ENABLE2:    s_nxt.dat = {16'h0000, s_r.ie2};
        `OFS_SLAVE_ADDR: s_nxt.dat = {24'h000000, s_r.sla}; // RULE20
        `OFS_DATA_BUF:   s_nxt.dat = {24'h000000, s_r.rx_buf};
        `OFS_MEM_PTR:    s_nxt.dat = {21'h000000, s_r.mptr};
        default:         s_nxt.dat = 32'h00000000;
      endcase
    end

    if (wr) begin
      case (wb_adr_i)
        `OFS_CONTROL: begin
          cw = (cw & ~(wmask & `CTRL_WR_MASK)) | (wd & wmask & `CTRL_WR_MASK);
          // Enable cannot be dropped or raised mid-transfer
          if (!busy) begin
            s_nxt.ctrl.en = cw[`CTRL_EN_BIT];
          end
          s_nxt.ctrl.str_sel  = cw[`CTRL_STR_SEL_BIT];
          s_nxt.ctrl.ack_bit  = cw[`CTRL_ACK_BIT];
          s_nxt.ctrl.gc_en    = cw[`CTRL_GC_EN_BIT];
          s_nxt.ctrl.str_en   = cw[`CTRL_STR_EN_BIT];
          s_nxt.ctrl.smb_mode = cw[`CTRL_SMB_BIT];
        end
        `OFS_STATUS: begin
          s_nxt.st = (s_r.st & ~(wmask & `ST_CLR_MASK & ~wd))
                     | (wmask & `ST_SET_MASK & wd); // RULE13 RULE21
        end
        `OFS_ENABLE:  s_nxt.ie = (s_r.ie & ~wmask) | (wd & wmask & `IE_MASK);
        `OFS_STATUS2: begin
          s_nxt.st2 = (s_r.st2 & ~(wmask & `ST2_CLR_MASK & ~wd))
                      | (wmask & `ST2_SET_MASK & wd); // RULE13 RULE21
        end
        `OFS_ENABLE2: s_nxt.ie2 = (s_r.ie2 & ~wmask) | (wd & wmask & `IE2_MASK);
        `OFS_SLAVE_ADDR: begin
          if (wb_sel_i[0]) begin
            s_nxt.sla = wd[7:0]; // RULE20
          end
        end
        `OFS_DATA_BUF: begin
          if (wb_sel_i[0]) begin
            s_nxt.tx_buf = wd[7:0];
          end
        end
        `OFS_MEM_PTR: begin
          s_nxt.mptr = 11'((s_r.mptr & ~wmask[10:0]) | (wd & wmask & `MPTR_MASK));
        end
        default: begin
        end
      endcase
    end

    if (rd && (wb_adr_i == `OFS_DATA_BUF)) begin
      s_nxt.rx_unread = 1'b0;
      s_nxt.st[`ST_OVERRUN_BIT] = 1'b0; // RULE4
    end

    // Link engine; hardware sets come after bus writes so a set wins
    if (!s_r.ctrl.en) begin
      s_nxt.state   = i2c_slave_pkg::ST_IDLE;
      s_nxt.bus_act = 1'b0; // RULE1
      s_nxt.sda_oe  = 1'b0;
      s_nxt.st[`ST_STRETCH_BIT] = 1'b0;
    end else if (stop_ev) begin
      s_nxt.state   = i2c_slave_pkg::ST_IDLE;
      s_nxt.bus_act = 1'b0; // RULE1
      s_nxt.sda_oe  = 1'b0;
      s_nxt.st2[`ST2_STOP_BIT] = 1'b1; // RULE15
    end else if (start_ev) begin
      s_nxt.state   = i2c_slave_pkg::ST_ADDR;
      s_nxt.cnt     = 4'h0;
      s_nxt.bus_act = 1'b1; // RULE1
      s_nxt.sda_oe  = 1'b0;
      s_nxt.expect_mem = 1'b0;
      s_nxt.st[`ST_START_BIT] = 1'b1; // RULE12
    end else begin
      case (s_r.state)
        i2c_slave_pkg::ST_IDLE: begin
        end
        i2c_slave_pkg::ST_ADDR: begin
          if (scl_rise) begin
            s_nxt.shift = {s_r.shift[6:0], sda_f};
            s_nxt.cnt   = 4'(s_r.cnt + 4'h1);
            if (4'(s_r.cnt + 4'h1) == `APHASE_EDGES) begin
              s_nxt.st2[`ST2_APHASE_BIT] = 1'b1; // RULE16
            end
          end else if (scl_fall && at_last) begin
            hit   = (s_r.shift[7:1] == s_r.sla[7:1]);
            gcall = (s_r.shift == `GCALL_ADDR) & s_r.ctrl.gc_en; // RULE23
            if (hit) begin
              s_nxt.st[`ST_AMATCH_BIT] = 1'b1; // RULE7
              s_nxt.sla[0]     = s_r.shift[0]; // RULE20
              s_nxt.rd_dir     = s_r.shift[0];
              s_nxt.expect_mem = ~s_r.shift[0]; // RULE18
            end
            if (gcall) begin
              s_nxt.st[`ST_GCALL_BIT] = 1'b1; // RULE5
              s_nxt.rd_dir = 1'b0;
            end
            if (hit | gcall) begin
              s_nxt.state  = i2c_slave_pkg::ST_AACK;
              s_nxt.sda_oe = 1'b1;
              set_str      = s_r.ctrl.str_sel;
            end else begin
              // Other slave addressed: drop out until next START
              s_nxt.state = i2c_slave_pkg::ST_IDLE;
            end
          end
        end
        i2c_slave_pkg::ST_AACK: begin
          if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            set_str   = ~s_r.ctrl.str_sel;
            if (s_r.rd_dir) begin
              s_nxt.state  = i2c_slave_pkg::ST_TXD;
              s_nxt.shift  = s_r.tx_buf;
              s_nxt.sda_oe = ~s_r.tx_buf[7];
            end else begin
              s_nxt.state  = i2c_slave_pkg::ST_RXD;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        i2c_slave_pkg::ST_RXD: begin
          if (scl_rise) begin
            s_nxt.shift = {s_r.shift[6:0], sda_f};
            s_nxt.cnt   = 4'(s_r.cnt + 4'h1);
          end else if (scl_fall && at_last) begin
            s_nxt.rx_buf    = s_r.shift;
            s_nxt.rx_unread = 1'b1;
            s_nxt.st[`ST_RXRDY_BIT] = 1'b1; // RULE10
            if (s_r.rx_unread) begin
              s_nxt.st[`ST_OVERRUN_BIT] = 1'b1; // RULE4
            end
            if (s_r.expect_mem) begin
              s_nxt.mptr[7:0]  = s_r.shift; // RULE17 RULE18
              s_nxt.expect_mem = 1'b0;
              s_nxt.st2[`ST2_MADDR_BIT] = 1'b1; // RULE17
            end
            s_nxt.state  = i2c_slave_pkg::ST_RACK;
            s_nxt.sda_oe = ~s_r.ctrl.ack_bit;
            set_str      = s_r.ctrl.str_sel;
          end
        end
        i2c_slave_pkg::ST_RACK: begin
          if (scl_fall) begin
            s_nxt.state  = i2c_slave_pkg::ST_RXD;
            s_nxt.cnt    = 4'h0;
            s_nxt.sda_oe = 1'b0;
            set_str      = ~s_r.ctrl.str_sel;
          end
        end
        i2c_slave_pkg::ST_TXD: begin
          if (scl_rise) begin
            s_nxt.cnt = 4'(s_r.cnt + 4'h1);
          end else if (scl_fall && at_last) begin
            s_nxt.state  = i2c_slave_pkg::ST_TACK;
            s_nxt.sda_oe = 1'b0;
            set_str      = s_r.ctrl.str_sel;
          end else if (scl_fall) begin
            s_nxt.shift  = {s_r.shift[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.shift[6];
          end
        end
        i2c_slave_pkg::ST_TACK: begin
          if (scl_rise) begin
            s_nxt.host_ack = ~sda_f;
            s_nxt.st[`ST_NACK_BIT]     = sda_f; // RULE6
            s_nxt.st[`ST_TXDONE_BIT]   = 1'b1; // RULE11
            s_nxt.st2[`ST2_TXCOPY_BIT] = 1'b1; // RULE11
          end else if (scl_fall) begin
            if (s_r.host_ack) begin
              s_nxt.state  = i2c_slave_pkg::ST_TXD;
              s_nxt.cnt    = 4'h0;
              s_nxt.shift  = s_r.tx_buf;
              s_nxt.sda_oe = ~s_r.tx_buf[7];
              set_str      = ~s_r.ctrl.str_sel;
            end else begin
              // Host NACK ends the read; wait for STOP or START
              s_nxt.state = i2c_slave_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          s_nxt.state  = i2c_slave_pkg::ST_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    if (set_str && s_r.ctrl.str_en) begin
      s_nxt.st[`ST_STRETCH_BIT] = 1'b1; // RULE9
    end
    // SCL held exactly while the stretch flag stands
    s_nxt.scl_oe = s_nxt.st[`ST_STRETCH_BIT] & s_r.ctrl.en; // RULE9

    // Timeout counter clears whenever inactive, so only one unbroken low counts
    if (s_r.ctrl.en && s_r.ctrl.smb_mode && busy && !scl_f) begin // RULE22
      if (s_r.tocnt == TO_LIM) begin
        s_nxt.st[`ST_TIMEOUT_BIT] = 1'b1; // RULE8
      end else begin
        s_nxt.tocnt = TO_W'(s_r.tocnt + 1'b1);
      end
    end else begin
      s_nxt.tocnt = '0;
    end

    s_nxt.irq = |((s_nxt.st & s_nxt.ie & `IE_MASK)
                  | (s_nxt.st2 & s_nxt.ie2 & `IE2_MASK)); // RULE14 RULE19 RULE24
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r            <= '0;
      s_r.ctrl.en    <= CTRL_RST[`CTRL_EN_BIT];
      s_r.st         <= `FLAGS_RESET;
      s_r.st2        <= `FLAGS_RESET;
      s_r.sla        <= `SLA_RESET; // RULE20
      s_r.state      <= i2c_slave_pkg::ST_IDLE;
      s_r.scl_d      <= 1'b1;
      s_r.sda_d      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign scl_oe   = s_r.scl_oe;
  assign sda_oe   = s_r.sda_oe;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign irq      = s_r.irq;
endmodule : i2c_slave_status

// file: rtl/pin_sync3.sv
// Three-flop synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic din,
  output logic      q
);
  i2c_slave_pkg::sync_s s_r;
  i2c_slave_pkg::sync_s s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = din;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    // Change accepted only once the two settled stages agree
    if (s_r.ff2 == s_r.ff3) begin
      s_nxt.q = s_r.ff3;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule : pin_sync3
